//--- src/mot_od_tunnel.sv
// Overview of operation
// - Frame is address, 2B, 0D, options of 2-4 bytes, address area, CRC.
// - Options: flag field, zero reserved byte, counter byte only if flagged.
// - Flag bit 0 is the MSB of flag byte 1; bits 8-15 in byte 2.
// - Flag bit 1 set means a second flag byte is present.
// - Flag bit 2 set means the counter byte is present.
// - Flag bit 7 selects read (0) or write (1).
// - Node 01-7F, index, subindex, start, count up to 00FD, high first.
// - Only the master starts accesses; addressed requests get a reply; none sent for other function or MEI codes or truncated frames.
// - Error reply: AB, FF, length 6, 0D, CE, four-byte error code.
`timescale 1ns/1ns
`default_nettype none
module mot_od_tunnel
  import mot_pkg::*;
#(
  parameter int DATA_MAX = 253
)(
  input wire logic clk, // 20 MHz clock.
  input wire logic srst, // Synchronous reset.
  input wire logic [7:0] ownAddr, // Server address of this device.
  input wire logic rxValid, // Request byte strobe, CRC stripped.
  input wire logic [7:0] rxData, // Request byte.
  input wire logic rxEnd, // Frame end pulse after the last byte.
  output logic busy_ff, // Request being served.
  output mot_od_req_t odReq_ff, // Decoded dictionary request.
  output logic odReqValid_ff, // One-cycle dictionary request pulse.
  input wire logic [7:0] odBufAddr, // Data buffer read address.
  output logic [7:0] odBufData_ff, // Data buffer byte, one cycle late.
  input wire logic odRdValid, // Read data byte strobe.
  input wire logic [7:0] odRdData, // Read data byte, LSB first.
  input wire logic odRspValid, // Dictionary completion pulse.
  input wire mot_od_rsp_t odRsp, // Completion status and length.
  output logic txValid_ff, // Response byte valid.
  output logic [7:0] txData_ff, // Response byte.
  output logic txLast_ff, // Last byte of the response.
  input wire logic txReady // Response byte taken.
);

  mot_state_t state_ff;
  logic [7:0] hdr_ff [0:HDR_MAX-1];
  logic [7:0] buf_ff [0:DATA_MAX-1];
  logic [4:0] hdrLen_ff;
  logic [3:0] fldIdx_ff;
  logic [8:0] dataCnt_ff;
  logic [8:0] txIdx_ff;
  logic [8:0] txTotal_ff;
  logic [31:0] errCode_ff;
  logic errResp_ff;
  logic badFlags_ff;
  logic extFlag_ff;
  logic cntFlag_ff;
  logic [15:0] cntOut_ff;
  logic rxByte;
  logic parsing;
  logic sendDone;
  logic [7:0] nextByte;
  logic [31:0] evalErr;

  function automatic logic flagBit(input logic [7:0] b, input int k);
    flagBit = b[7-k];
  endfunction : flagBit

  assign parsing = !(state_ff inside {ST_DICT, ST_SEND});
  assign rxByte = rxValid && parsing;
  assign sendDone = txValid_ff && txReady && txLast_ff;

  always_comb
  begin
    evalErr = 32'h0000_0000;
    if (badFlags_ff)
      evalErr = ERR_UNSUPPORTED;
    else if (odReq_ff.count > COUNT_MAX)
      evalErr = ERR_TOO_LONG;
    else if (odReq_ff.targetNodeNumber < NODE_MIN ||
             odReq_ff.targetNodeNumber > NODE_MAX)
      evalErr = ERR_BAD_CMD;
    else if (dataCnt_ff != (odReq_ff.write ? odReq_ff.count[8:0] : 9'h000))
      evalErr = ERR_LEN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame parser and sequencing.
  always_ff @(posedge clk)
  begin
    if (srst)
      state_ff <= ST_ADDR;
    else if (rxEnd && parsing)
    begin
      if (state_ff == ST_DATA)
        state_ff <= (evalErr != 32'h0000_0000) ? ST_SEND : ST_DICT;
      else
        state_ff <= ST_ADDR; // Truncated or foreign frames get no reply.
    end
    else if (rxByte)
    begin
      case (state_ff)
        ST_ADDR:
          state_ff <= (rxData == ownAddr && ownAddr != 8'h00) ?
                      ST_FUNC : ST_SKIP;
        ST_FUNC:
          state_ff <= (rxData == FUNC_CODE) ? ST_MEI : ST_SKIP;
        ST_MEI:
          state_ff <= (rxData == MEI_TYPE) ? ST_FLAG1 : ST_SKIP;
        ST_FLAG1:
          state_ff <= flagBit(rxData, FLAG_EXT) ? ST_FLAG2 : ST_RSVD;
        ST_FLAG2:
          state_ff <= ST_RSVD;
        ST_RSVD:
          state_ff <= cntFlag_ff ? ST_CNTR : ST_FIELDS;
        ST_CNTR:
          state_ff <= ST_FIELDS;
        ST_FIELDS:
          if (fldIdx_ff == ADDR_FIELD_BYTES - 4'h1)
            state_ff <= ST_DATA;
        default:
          state_ff <= state_ff;
      endcase
    end
    else if (state_ff == ST_DICT && odRspValid)
      state_ff <= ST_SEND;
    else if (state_ff == ST_SEND && sendDone)
      state_ff <= ST_ADDR;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      busy_ff <= 1'b0;
    else
      busy_ff <= !parsing;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option flags and address area capture.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      badFlags_ff <= 1'b0;
      extFlag_ff <= 1'b0;
      cntFlag_ff <= 1'b0;
      fldIdx_ff <= 4'h0;
      odReq_ff <= '0;
    end
    else if (rxByte)
    begin
      case (state_ff)
        ST_ADDR:
        begin
          badFlags_ff <= 1'b0;
          fldIdx_ff <= 4'h0;
        end
        ST_FLAG1:
        begin
          odReq_ff.multi <= flagBit(rxData, FLAG_MULTI);
          extFlag_ff <= flagBit(rxData, FLAG_EXT);
          cntFlag_ff <= flagBit(rxData, FLAG_CNT);
          odReq_ff.write <= flagBit(rxData, FLAG_WRITE);
          badFlags_ff <= flagBit(rxData, FLAG_RES3) ||
                         flagBit(rxData, FLAG_RES4) ||
                         flagBit(rxData, FLAG_NETID) ||
                         flagBit(rxData, FLAG_ENC);
        end
        ST_FLAG2:
          badFlags_ff <= badFlags_ff || rxData != 8'h00;
        ST_RSVD:
          badFlags_ff <= badFlags_ff || rxData != 8'h00;
        ST_FIELDS:
        begin
          fldIdx_ff <= fldIdx_ff + 4'h1;
          case (fldIdx_ff)
            4'h0: odReq_ff.targetNodeNumber <= rxData;
            4'h1: odReq_ff.index[15:8] <= rxData;
            4'h2: odReq_ff.index[7:0] <= rxData;
            4'h3: odReq_ff.subIndex <= rxData;
            4'h4: odReq_ff.start[15:8] <= rxData;
            4'h5: odReq_ff.start[7:0] <= rxData;
            4'h6: odReq_ff.count[15:8] <= rxData;
            default: odReq_ff.count[7:0] <= rxData;
          endcase
        end
        default:
          fldIdx_ff <= fldIdx_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Echo header store and data buffer.
  always_ff @(posedge clk)
  begin
    if (srst)
      hdrLen_ff <= 5'h00;
    else if (rxByte && state_ff == ST_ADDR)
    begin
      hdr_ff[0] <= rxData;
      hdrLen_ff <= 5'h01;
    end
    else if (rxByte && !(state_ff inside {ST_DATA, ST_SKIP}))
    begin
      hdr_ff[hdrLen_ff[3:0]] <= rxData;
      hdrLen_ff <= hdrLen_ff + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      dataCnt_ff <= 9'h000;
    else if (rxByte && state_ff == ST_ADDR)
      dataCnt_ff <= 9'h000;
    else if (rxByte && state_ff == ST_DATA)
    begin
      if (dataCnt_ff < 9'(DATA_MAX))
        buf_ff[dataCnt_ff[7:0]] <= rxData;
      if (dataCnt_ff != 9'h1FF)
        dataCnt_ff <= dataCnt_ff + 9'h001;
    end
    else if (state_ff == ST_DICT && odRdValid)
    begin
      if (dataCnt_ff < 9'(DATA_MAX))
        buf_ff[dataCnt_ff[7:0]] <= odRdData;
      dataCnt_ff <= dataCnt_ff + 9'h001;
    end
    else if (state_ff == ST_DATA && rxEnd && evalErr == 32'h0000_0000 &&
             !odReq_ff.write)
      dataCnt_ff <= 9'h000;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      odBufData_ff <= 8'h00;
    else
      odBufData_ff <= buf_ff[odBufAddr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dictionary request and response selection.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      odReqValid_ff <= 1'b0;
      errResp_ff <= 1'b0;
      errCode_ff <= 32'h0000_0000;
      cntOut_ff <= 16'h0000;
      txTotal_ff <= 9'h000;
    end
    else
    begin
      odReqValid_ff <= 1'b0;
      if (state_ff == ST_DATA && rxEnd)
      begin
        errResp_ff <= evalErr != 32'h0000_0000;
        errCode_ff <= evalErr;
        txTotal_ff <= ERR_FRAME_LEN;
        odReqValid_ff <= evalErr == 32'h0000_0000;
      end
      else if (state_ff == ST_DICT && odRspValid)
      begin
        errResp_ff <= odRsp.err;
        errCode_ff <= odRsp.code;
        if (odRsp.err)
          txTotal_ff <= ERR_FRAME_LEN;
        else if (odReq_ff.write)
        begin
          cntOut_ff <= 16'h0000;
          txTotal_ff <= {4'h0, hdrLen_ff};
        end
        else
        begin
          cntOut_ff <= {8'h00, odRsp.len};
          txTotal_ff <= {4'h0, hdrLen_ff} + {1'b0, odRsp.len};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response byte stream.
  always_comb
  begin
    nextByte = 8'h00;
    if (errResp_ff)
    begin
      case (txIdx_ff[3:0])
        4'h0: nextByte = ownAddr;
        4'h1: nextByte = FUNC_CODE | EXC_FLAG;
        4'h2: nextByte = EXC_EXTENDED;
        4'h3: nextByte = EXC_LEN_HI;
        4'h4: nextByte = EXC_LEN_LO;
        4'h5: nextByte = MEI_TYPE;
        4'h6: nextByte = EXC_CODE;
        4'h7: nextByte = errCode_ff[31:24];
        4'h8: nextByte = errCode_ff[23:16];
        4'h9: nextByte = errCode_ff[15:8];
        default: nextByte = errCode_ff[7:0];
      endcase
    end
    else if (txIdx_ff < {4'h0, hdrLen_ff} - 9'h002)
      nextByte = hdr_ff[txIdx_ff[3:0]];
    else if (txIdx_ff == {4'h0, hdrLen_ff} - 9'h002)
      nextByte = cntOut_ff[15:8];
    else if (txIdx_ff == {4'h0, hdrLen_ff} - 9'h001)
      nextByte = cntOut_ff[7:0];
    else
      nextByte = buf_ff[8'(txIdx_ff - {4'h0, hdrLen_ff})];
  end

  always_ff @(posedge clk)
  begin
    if (srst || state_ff != ST_SEND || sendDone)
    begin
      txValid_ff <= 1'b0;
      txData_ff <= 8'h00;
      txLast_ff <= 1'b0;
      txIdx_ff <= 9'h000;
    end
    else if (!txValid_ff || txReady)
    begin
      txValid_ff <= 1'b1;
      txData_ff <= nextByte;
      txLast_ff <= txIdx_ff == txTotal_ff - 9'h001;
      txIdx_ff <= txIdx_ff + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_fc_reject: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_FUNC && rxByte && !rxEnd && rxData != FUNC_CODE
    |=> state_ff == ST_SKIP)
    else $error("Wrong function code not skipped.");
  a_bit_order: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_FLAG1 && rxByte && !rxEnd
    |=> odReq_ff.write == $past(rxData[0]) &&
        odReq_ff.multi == $past(rxData[7]))
    else $error("Flag bit numbering wrong.");
  a_ext_skip: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_FLAG1 && rxByte && !rxEnd && !rxData[6]
    |=> state_ff == ST_RSVD)
    else $error("Second flag byte expected wrongly.");
  a_cnt_opt: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_RSVD && rxByte && !rxEnd
    |=> state_ff == (cntFlag_ff ? ST_CNTR : ST_FIELDS))
    else $error("Counter byte handling wrong.");
  a_req_range: assert property (@(posedge clk) disable iff (srst)
    odReqValid_ff |-> odReq_ff.count <= COUNT_MAX &&
    odReq_ff.targetNodeNumber inside {[NODE_MIN:NODE_MAX]} ##1 !odReqValid_ff)
    else $error("Bad dictionary request issued.");
  a_reply_addr: assert property (@(posedge clk) disable iff (srst)
    $rose(txValid_ff) |-> txData_ff == ownAddr && txIdx_ff == 9'h001)
    else $error("Reply does not start with own address.");
  a_write_zero: assert property (@(posedge clk) disable iff (srst)
    txValid_ff && !errResp_ff && odReq_ff.write &&
    txIdx_ff >= {4'h0, hdrLen_ff} - 9'h001 |-> txData_ff == 8'h00)
    else $error("Write reply count not zero.");
  a_bad_flags: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_DATA && rxEnd && badFlags_ff
    |=> errResp_ff && errCode_ff == ERR_UNSUPPORTED && !odReqValid_ff)
    else $error("Bad flags not rejected.");
  a_err_frame: assert property (@(posedge clk) disable iff (srst)
    txValid_ff && errResp_ff && txIdx_ff == 9'h002
    |-> txData_ff == 8'hAB ##0 txTotal_ff == ERR_FRAME_LEN)
    else $error("Error reply function code wrong.");

  c_read_ok: cover property (@(posedge clk) disable iff (srst)
    sendDone && !errResp_ff && !odReq_ff.write);
  c_write_ok: cover property (@(posedge clk) disable iff (srst)
    sendDone && !errResp_ff && odReq_ff.write);
  c_error: cover property (@(posedge clk) disable iff (srst)
    sendDone && errResp_ff);
  c_two_flags: cover property (@(posedge clk) disable iff (srst)
    state_ff == ST_FLAG2 && rxByte);

endmodule : mot_od_tunnel
`default_nettype wire

//--- src/mot_pkg.sv
package mot_pkg;

  localparam logic [7:0] FUNC_CODE = 8'h2B;
  localparam logic [7:0] MEI_TYPE = 8'h0D;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_EXTENDED = 8'hFF;
  localparam logic [7:0] EXC_LEN_HI = 8'h00;
  localparam logic [7:0] EXC_LEN_LO = 8'h06;
  localparam logic [7:0] EXC_CODE = 8'hCE;
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'h7F;
  localparam logic [15:0] COUNT_MAX = 16'h00FD;

  localparam int FLAG_MULTI = 0;
  localparam int FLAG_EXT = 1;
  localparam int FLAG_CNT = 2;
  localparam int FLAG_RES3 = 3;
  localparam int FLAG_RES4 = 4;
  localparam int FLAG_NETID = 5;
  localparam int FLAG_ENC = 6;
  localparam int FLAG_WRITE = 7;

  localparam logic [31:0] ERR_UNSUPPORTED = 32'hFFFF1003;
  localparam logic [31:0] ERR_BAD_CMD = 32'hFFFF0003;
  localparam logic [31:0] ERR_LEN = 32'hFFFF0011;
  localparam logic [31:0] ERR_TOO_LONG = 32'hFFFF0012;

  localparam logic [3:0] ADDR_FIELD_BYTES = 4'h8;
  localparam logic [8:0] ERR_FRAME_LEN = 9'h00B;
  localparam int HDR_MAX = 16;

  typedef struct packed {
    logic write;
    logic multi;
    logic [7:0] targetNodeNumber;
    logic [15:0] index;
    logic [7:0] subIndex;
    logic [15:0] start;
    logic [15:0] count;
  } mot_od_req_t;

  typedef struct packed {
    logic err;
    logic [31:0] code;
    logic [7:0] len;
  } mot_od_rsp_t;

  typedef enum logic [11:0] {
    ST_ADDR = 12'h001,
    ST_FUNC = 12'h002,
    ST_MEI = 12'h004,
    ST_FLAG1 = 12'h008,
    ST_FLAG2 = 12'h010,
    ST_RSVD = 12'h020,
    ST_CNTR = 12'h040,
    ST_FIELDS = 12'h080,
    ST_DATA = 12'h100,
    ST_SKIP = 12'h200,
    ST_DICT = 12'h400,
    ST_SEND = 12'h800
  } mot_state_t;

endpackage : mot_pkg

//--- verif/mot_dict_model.sv
`timescale 1ns/1ns
`default_nettype none
module mot_dict_model
  import mot_pkg::*;
(
  input wire logic clk, // Clock.
  input wire mot_od_req_t odReq, // Decoded request.
  input wire logic odReqValid, // Request pulse.
  input wire logic [7:0] bufData, // Write data byte.
  input wire logic errIn, // Answer with an error.
  input wire logic [31:0] errCode, // Error code to return.
  input wire logic [7:0] waitCycles, // Extra latency.
  output logic [7:0] bufAddr, // Write data read address.
  output logic rdValid, // Read byte strobe.
  output logic [7:0] rdData, // Read byte.
  output logic rspValid, // Completion pulse.
  output mot_od_rsp_t rsp, // Completion status.
  output logic [31:0] wrSeen // First four write bytes seen.
);
  initial
  begin
    rdValid = 1'b0;
    rspValid = 1'b0;
    rdData = 8'h5A;
    rsp = '0;
    bufAddr = 8'h00;
    wrSeen = 32'h0;
  end

  // Read data goes out LSB first; released lines are inverted.
  task automatic serve;
    int i;
    repeat (waitCycles) @(posedge clk);
    #1;
    if (odReq.write)
      for (i = 0; i < int'(odReq.count); i++)
      begin
        bufAddr = i[7:0];
        @(posedge clk);
        #1;
        if (i < 4)
          wrSeen[8*i +: 8] = bufData;
      end
    else
      for (i = 0; i < int'(odReq.count); i++)
      begin
        rdValid = 1'b1;
        rdData = 8'hA0 + i[7:0];
        @(posedge clk);
        #1;
      end
    rdValid = 1'b0;
    rdData = ~rdData;
    rspValid = 1'b1;
    rsp = '{errIn, errCode, odReq.write ? 8'h00 : odReq.count[7:0]};
    @(posedge clk);
    #1;
    rspValid = 1'b0;
    rsp = ~rsp;
  endtask : serve

  always @(posedge clk)
    if (odReqValid === 1'b1)
      serve();
endmodule : mot_dict_model
`default_nettype wire

//--- verif/test_mot_od_tunnel.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module test_mot_od_tunnel
  import mot_pkg::*;
;
  logic clk, srst, rxValid, rxEnd, txReady, dictErr;
  logic [7:0] rxData, dly, bufAddr, bufData, rdData, txData;
  logic busy, reqValid, rdValid, rspValid, txValid, txLast;
  logic [31:0] dictCode, wrSeen;
  mot_od_req_t odReq;
  mot_od_rsp_t rsp;
  int n_errors = 0;
  int n_tests = 0;
  int i;
  logic [7:0] frameQ[$], gotQ[$];

  mot_od_tunnel i_mot_od_tunnel (.clk(clk), .srst(srst),
    .ownAddr(8'h05), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
    .busy_ff(busy), .odReq_ff(odReq), .odReqValid_ff(reqValid),
    .odBufAddr(bufAddr), .odBufData_ff(bufData), .odRdValid(rdValid),
    .odRdData(rdData), .odRspValid(rspValid), .odRsp(rsp),
    .txValid_ff(txValid), .txData_ff(txData), .txLast_ff(txLast),
    .txReady(txReady));

  mot_dict_model i_mot_dict_model (.clk(clk), .odReq(odReq),
    .odReqValid(reqValid), .bufData(bufData), .errIn(dictErr),
    .errCode(dictCode), .waitCycles(dly), .bufAddr(bufAddr),
    .rdValid(rdValid), .rdData(rdData), .rspValid(rspValid),
    .rsp(rsp), .wrSeen(wrSeen));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic send(input logic [7:0] req[$]);
    foreach (req[k])
    begin
      rxValid = 1'b1;
      rxData = req[k];
      @(posedge clk);
      #1;
    end
    rxValid = 1'b0;
    rxData = ~rxData;
    rxEnd = 1'b1;
    @(posedge clk);
    #1 rxEnd = 1'b0;
  endtask : send

  // The consumer stalls one cycle in three to exercise the hold.
  task automatic collect(output logic [7:0] got[$]);
    logic done;
    done = 1'b0;
    got = {};
    for (int k = 0; k < 1000 && !done; k++)
    begin
      if (txValid === 1'b1 && txReady === 1'b1)
      begin
        got.push_back(txData);
        done = (txLast === 1'b1);
      end
      @(posedge clk);
      #1 txReady = (k % 3 != 0);
    end
  endtask : collect

  task automatic run(input logic [7:0] ad, f1, f2, node,
    input logic [15:0] cnt, input int nData, input logic [31:0] code);
    logic [7:0] req[$], want[$], got[$];
    mot_od_req_t wantReq;
    wantReq = '{f1[0], f1[7], node, 16'h6041, 8'h02, 16'h1234, cnt};
    req = '{ad, FUNC_CODE, MEI_TYPE, f1};
    if (f1[6])
      req.push_back(f2);
    req.push_back(8'h00);
    if (f1[5])
      req.push_back(8'h07);
    req = {req, node, 8'h60, 8'h41, 8'h02, 8'h12, 8'h34};
    want = {req, 8'h00, f1[0] ? 8'h00 : cnt[7:0]};
    req = {req, cnt[15:8], cnt[7:0]};
    for (int k = 0; k < nData; k++)
      req.push_back(8'hE8 + k[7:0]);
    for (int k = 0; k < int'(cnt[7:0]) && !f1[0]; k++)
      want.push_back(8'hA0 + k[7:0]);
    if (code != 32'h0)
      want = {ad, FUNC_CODE | EXC_FLAG, EXC_EXTENDED, EXC_LEN_HI, EXC_LEN_LO,
        MEI_TYPE, EXC_CODE, code[31:24], code[23:16], code[15:8], code[7:0]};
    if (ad != 8'h05)
      want = {};
    send(req);
    collect(got);
    `CHK(got.size(), want.size())
    `CHK(busy, want.size() != 0)
    for (int k = 0; k < want.size() && k < got.size(); k++)
      `CHK(got[k], want[k])
    if (code == 32'h0 && ad == 8'h05)
    begin
      `CHK(odReq, wantReq)
      for (int k = 0; k < nData && k < 4; k++)
        `CHK(wrSeen[8*k +: 8], 8'hE8 + k[7:0])
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2_000_000;
    n_errors++;
    results();
  end

  initial
  begin
    srst = 1'b1;
    {rxValid, rxEnd, txReady, dictErr} = 4'h0;
    {rxData, dly, dictCode} = 48'h0;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    `CHK({txValid, reqValid, busy}, 3'h0)
    run(8'h05, 8'h00, 8'h00, 8'h01, 16'h0002, 0, 32'h0);
    dly = 8'h07;
    run(8'h05, 8'h01, 8'h00, 8'h01, 16'h0004, 4, 32'h0);
    dly = 8'h00;
    run(8'h05, 8'h01, 8'h00, 8'h01, 16'h0004, 2, ERR_LEN);
    run(8'h05, 8'h60, 8'h00, 8'h7F, 16'h0001, 0, 32'h0);
    run(8'h05, 8'h80, 8'h00, 8'h01, 16'h00FD, 0, 32'h0);
    for (i = 1; i < 5; i++)
      run(8'h05, 8'h01 << i, 8'h00, 8'h01, 16'h2, 0,
        ERR_UNSUPPORTED);
    run(8'h05, 8'h40, 8'h01, 8'h01, 16'h0002, 0,
      ERR_UNSUPPORTED);
    run(8'h05, 8'h00, 8'h00, 8'h01, 16'h00FE, 0, ERR_TOO_LONG);
    run(8'h05, 8'h00, 8'h00, 8'h00, 16'h0002, 0, ERR_BAD_CMD);
    run(8'h05, 8'h00, 8'h00, 8'h80, 16'h0002, 0, ERR_BAD_CMD);
    run(8'h06, 8'h00, 8'h00, 8'h01, 16'h0002, 0, 32'h0);
    frameQ = {8'h05, 8'h03, MEI_TYPE, 8'h00, 8'h00, 8'h01};
    send(frameQ);
    collect(gotQ);
    `CHK(gotQ.size(), 0)
    dictErr = 1'b1;
    dictCode = 32'hFFFF0008;
    run(8'h05, 8'h00, 8'h00, 8'h01, 16'h0002, 0, 32'hFFFF0008);
    dictErr = 1'b0;
    run(8'h05, 8'h00, 8'h00, 8'h01, 16'h0003, 0, 32'h0);
    results();
  end
endmodule : test_mot_od_tunnel
`default_nettype wire
